// [hdl/qrw_pkg.sv]
package qrw_pkg;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_QIO_READ3 = 8'hEB;
  localparam logic [7:0] OP_QIO_READ4 = 8'hEC;
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  localparam logic [7:0] OP_PARAM_SET = 8'hC0;
  localparam logic [7:0] OP_PROG3 = 8'h02;
  localparam logic [7:0] OP_PROG4 = 8'h12;

  // ----------------------------------------------------------------
  // Register layout and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATENCY_RESET = 8'h00;
  localparam logic [7:0] LATENCY_KEEP_MASK = 8'h70;
  localparam int LATENCY_LSB = 4;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_SIZE_LSB = 5;
  localparam logic WRAP_DIS_RESET = 1'b1;
  localparam logic [1:0] WRAP_SIZE_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Last serial-clock index of each frame phase
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] QADDR3_LAST = 6'h05;
  localparam logic [5:0] QADDR4_LAST = 6'h07;
  localparam logic [5:0] SADDR3_LAST = 6'h17;
  localparam logic [5:0] SADDR4_LAST = 6'h1F;
  localparam logic [5:0] MODE_LAST = 6'h01;
  localparam logic [5:0] WDUM3_LAST = 6'h05;
  localparam logic [5:0] WDUM4_LAST = 6'h07;
  localparam logic [5:0] QBYTE_LAST = 6'h01;
  localparam logic [5:0] SBYTE_LAST = 6'h07;
  localparam logic [8:0] PAGE_END = 9'h100;

  // Dummy clocks per latency code, wrap masks per size code
  localparam logic [5:0] DUMMY_TABLE [8] = '{6'h06, 6'h06, 6'h06, 6'h08,
                                             6'h0A, 6'h0C, 6'h0E, 6'h10};
  localparam logic [7:0] WRAP_MASK_TABLE [4] = '{8'h07, 8'h0F, 8'h1F, 8'h3F};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_RDATA,
    ST_WDUMMY, ST_WBYTE, ST_PARAM, ST_PDATA, ST_IGNORE
  } qrw_state_type;

  typedef struct packed {
    logic [1:0] wrap_size_field;
    logic wrap_disable_bit;
  } qrw_wrap_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
  } qrw_prog_type;

  function automatic logic [31:0] qrw_next_addr(input logic [31:0] a,
                                                input qrw_wrap_type w);
    logic [7:0] m;
    logic [7:0] inc;
    m = WRAP_MASK_TABLE[w.wrap_size_field];
    inc = a[7:0] + 8'h01;
    if (w.wrap_disable_bit) begin
      qrw_next_addr = a + 32'h0000_0001;
    end else begin
      qrw_next_addr = {a[31:8], (a[7:0] & ~m) | (inc & m)};
    end
  endfunction

endpackage

// [hdl/qrw_page_buf.sv]
`timescale 1ns/1ps
module qrw_page_buf (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] raddr_i,
  output logic [7:0] rdata_o
);
  import qrw_pkg::*;

  logic [7:0] mem_ff [256];
  logic [7:0] rdata_ff;

  // Array itself has no reset; only loaded bytes are ever used
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (ce_i) begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule

// [hdl/qrw_skid.sv]
`timescale 1ns/1ps
module qrw_skid (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [7:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i
);
  import qrw_pkg::*;

  logic [7:0] ent_ff [2];
  logic [7:0] nxt_ent [2];
  logic rd_ptr_ff, nxt_rd_ptr;
  logic [1:0] cnt_ff, nxt_cnt;
  logic rdy_ff, nxt_rdy;
  logic push, pop;
  logic wr_ptr;

  always_comb begin
    push = in_valid_i && rdy_ff;
    pop = out_ready_i && (cnt_ff != 2'h0);
    wr_ptr = rd_ptr_ff ^ cnt_ff[0];
    nxt_ent = ent_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_ent[wr_ptr] = in_data_i;
    end
    if (pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    if (flush_i) begin
      nxt_cnt = 2'h0;
      nxt_rd_ptr = 1'b0;
    end
    nxt_rdy = (nxt_cnt != 2'h2);
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ent_ff <= '{8'h00, 8'h00};
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      rdy_ff <= 1'b1;
    end else if (ce_i) begin
      ent_ff <= nxt_ent;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
      rdy_ff <= nxt_rdy;
    end
  end

  assign in_ready_o = rdy_ff;
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = ent_ff[rd_ptr_ff];
endmodule

// [hdl/qrw_core.sv]
// What this block does
// - Command ECh always takes a 32-bit address in either address mode.
// - Command ECh is accepted only in standard single-line serial mode.
// - With wrap on, read output wraps inside its aligned section until select rises.
// - Wrap setup is 77h, then 24 or 32 dummy bits, then one setting byte.
// - Bit 7 and bits 3 to 0 of the wrap setting byte are ignored.
// - Wrap disable bit 0 enables wrap, 1 disables it and voids the size.
// - Wrap size 00/01/10/11 selects 8/16/32/64 byte sections.
// - Stored wrap setting applies to all later quad reads until rewritten.
// - Wrap disable bit is 1 after power on and any reset.
// - In 4-byte address mode wrap setup carries 32 dummy bits.
// - Command C0h updates only the 3-bit dummy field, ignores wrap length bits.
// - Dummy codes 000-010 give 6 clocks, then 8,10,12,14,16.
// - Read parameter bits reset to zero, giving 6 dummy clocks.
// - Only the two quad reads use the configurable dummy count.
// - Page program is 02h, 24/32-bit address, data bytes on the single line.
// - Page program is rejected unless the write latch flag is set.
// - Program data wraps within its 256-byte page, overwriting earlier bytes.
// - Program runs only if select rises right after a data byte's eighth bit.
// - Busy stays 1 during the program cycle and clears when done.
// - Quad reads are accepted only with the quad I/O enable bit set.
`timescale 1ns/1ps
module qrw_core (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic [3:0] spi_io_i,
  output logic [3:0] spi_io_o,
  output logic [3:0] spi_io_oe_o,
  input wire logic quad_io_enable_i,
  input wire logic quad_peripheral_mode_i,
  input wire logic addr4_mode_i,
  input wire logic write_latch_flag_i,
  input wire logic page_protected_i,
  output logic busy_o,
  output logic write_latch_clear_o,
  output logic rd_req_o,
  output logic [31:0] rd_addr_o,
  input wire logic rd_valid_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_ready_o,
  output logic prog_we_o,
  output qrw_pkg::qrw_prog_type prog_o
);
  import qrw_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_ff, sclk_sync_ff;
  logic [3:0] io_s1_ff, io_s2_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cs_sync_ff <= 3'h7;
      sclk_sync_ff <= 3'h0;
      io_s1_ff <= 4'h0;
      io_s2_ff <= 4'h0;
    end else if (ce_i) begin
      cs_sync_ff <= {cs_sync_ff[1:0], spi_cs_n_i};
      sclk_sync_ff <= {sclk_sync_ff[1:0], spi_sclk_i};
      io_s1_ff <= spi_io_i;
      io_s2_ff <= io_s1_ff;
    end
  end

  logic cs_high, cs_rise, cs_fall, sclk_rise, sclk_fall;
  assign cs_high = cs_sync_ff[1];
  assign cs_rise = cs_sync_ff[1] && !cs_sync_ff[2];
  assign cs_fall = !cs_sync_ff[1] && cs_sync_ff[2];
  assign sclk_rise = sclk_sync_ff[1] && !sclk_sync_ff[2];
  assign sclk_fall = !sclk_sync_ff[1] && sclk_sync_ff[2];

  // ----------------------------------------------------------------
  // Frame decoder, configuration and read data path
  // ----------------------------------------------------------------
  qrw_state_type state_ff, nxt_state;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [31:0] sh_ff, nxt_sh;
  logic quad_ff, nxt_quad, is4_ff, nxt_is4;
  logic [31:0] addr_ff, nxt_addr, fetch_ff, nxt_fetch, rdaddr_ff, nxt_rdaddr;
  qrw_wrap_type burst_wrap_setting_ff, nxt_wrap;
  logic [7:0] read_latency_config_ff, nxt_latency;
  logic pend_ff, nxt_pend, rdreq_ff, nxt_rdreq;
  logic [7:0] out_ff, nxt_out, pofs_ff, nxt_pofs;
  logic nib_hi_ff, nxt_nib_hi, anyb_ff, nxt_anyb, go_ff, nxt_go;
  logic [3:0] io_ff, nxt_io, oe_ff, nxt_oe;
  logic [255:0] mask_ff, nxt_mask;
  logic buf_we, skid_pop, skid_in_ready, skid_valid, reading;
  logic [7:0] skid_data, buf_rdata, byte_s;
  logic [31:0] sh_s, sh_q;
  logic engine_busy;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_quad = quad_ff;
    nxt_is4 = is4_ff;
    nxt_addr = addr_ff;
    nxt_fetch = fetch_ff;
    nxt_rdaddr = rdaddr_ff;
    nxt_wrap = burst_wrap_setting_ff;
    nxt_latency = read_latency_config_ff;
    nxt_pend = pend_ff && !rd_valid_i;
    nxt_rdreq = 1'b0;
    nxt_out = out_ff;
    nxt_nib_hi = nib_hi_ff;
    nxt_io = io_ff;
    nxt_oe = oe_ff;
    nxt_pofs = pofs_ff;
    nxt_anyb = anyb_ff;
    nxt_mask = mask_ff;
    nxt_go = 1'b0;
    buf_we = 1'b0;
    skid_pop = 1'b0;
    sh_s = {sh_ff[30:0], io_s2_ff[0]};
    sh_q = {sh_ff[27:0], io_s2_ff};
    byte_s = sh_s[7:0];
    if (cs_high) begin
      nxt_oe = 4'h0;
      nxt_state = ST_IDLE;
      // Whole bytes only, and never on a protected page
      if (cs_rise && state_ff == ST_PDATA && cnt_ff == 6'h00 && anyb_ff &&
          !page_protected_i) begin
        nxt_go = 1'b1;
      end
    end else if (cs_fall) begin
      nxt_cnt = 6'h00;
      nxt_oe = 4'h0;
      // Quad peripheral mode frames are not decoded here at all
      nxt_state = (engine_busy || quad_peripheral_mode_i) ? ST_IGNORE : ST_OPCODE;
    end else if (sclk_rise) begin
      nxt_cnt = cnt_ff + 6'h01;
      unique case (state_ff)
        ST_OPCODE: begin
          nxt_sh = sh_s;
          if (cnt_ff == OPC_LAST) begin
            nxt_cnt = 6'h00;
            nxt_state = ST_IGNORE;
            nxt_quad = 1'b0;
            nxt_is4 = addr4_mode_i;
            if ((byte_s == OP_QIO_READ3 || byte_s == OP_QIO_READ4) &&
                quad_io_enable_i) begin
              nxt_state = ST_ADDR;
              nxt_quad = 1'b1;
              nxt_is4 = addr4_mode_i || (byte_s == OP_QIO_READ4);
            end else if (byte_s == OP_WRAP_SET) begin
              nxt_state = ST_WDUMMY;
            end else if (byte_s == OP_PARAM_SET) begin
              nxt_state = ST_PARAM;
            end else if ((byte_s == OP_PROG3 || byte_s == OP_PROG4) &&
                         write_latch_flag_i) begin
              nxt_state = ST_ADDR;
              nxt_is4 = addr4_mode_i || (byte_s == OP_PROG4);
            end
          end
        end
        ST_ADDR: begin
          nxt_sh = quad_ff ? sh_q : sh_s;
          if (cnt_ff == (quad_ff ? (is4_ff ? QADDR4_LAST : QADDR3_LAST)
                                 : (is4_ff ? SADDR4_LAST : SADDR3_LAST))) begin
            nxt_cnt = 6'h00;
            nxt_addr = is4_ff ? nxt_sh : {8'h00, nxt_sh[23:0]};
            nxt_fetch = nxt_addr;
            nxt_pofs = nxt_addr[7:0];
            nxt_mask = '0;
            nxt_anyb = 1'b0;
            nxt_state = quad_ff ? ST_MODE : ST_PDATA;
          end
        end
        ST_MODE: begin
          if (cnt_ff == MODE_LAST) begin
            nxt_cnt = 6'h00;
            nxt_state = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Configured latency serves only these quad reads
          if (cnt_ff == DUMMY_TABLE[read_latency_config_ff[LATENCY_LSB +: 3]] - 6'h01) begin
            nxt_cnt = 6'h00;
            nxt_state = ST_RDATA;
            nxt_nib_hi = 1'b1;
          end
        end
        ST_WDUMMY: begin
          if (cnt_ff == (addr4_mode_i ? WDUM4_LAST : WDUM3_LAST)) begin
            nxt_cnt = 6'h00;
            nxt_state = ST_WBYTE;
          end
        end
        ST_WBYTE: begin
          nxt_sh = sh_q;
          if (cnt_ff == QBYTE_LAST) begin
            // Only bits 6 to 4 are kept
            nxt_wrap.wrap_disable_bit = sh_q[WRAP_DIS_POS];
            nxt_wrap.wrap_size_field = sh_q[WRAP_SIZE_LSB +: 2];
            nxt_state = ST_IGNORE;
          end
        end
        ST_PARAM: begin
          nxt_sh = sh_s;
          if (cnt_ff == SBYTE_LAST) begin
            nxt_latency = (read_latency_config_ff & ~LATENCY_KEEP_MASK) |
                          (byte_s & LATENCY_KEEP_MASK);
            nxt_state = ST_IGNORE;
          end
        end
        ST_PDATA: begin
          nxt_sh = sh_s;
          if (cnt_ff == SBYTE_LAST) begin
            nxt_cnt = 6'h00;
            buf_we = 1'b1;
            nxt_mask[pofs_ff] = 1'b1;
            nxt_pofs = pofs_ff + 8'h01;
            nxt_anyb = 1'b1;
          end
        end
        default: begin
          nxt_cnt = cnt_ff;
        end
      endcase
    end else if (sclk_fall && state_ff == ST_RDATA) begin
      nxt_oe = 4'hF;
      nxt_nib_hi = !nib_hi_ff;
      if (nib_hi_ff) begin
        skid_pop = skid_valid;
        nxt_out = skid_valid ? skid_data : 8'hFF;
        nxt_io = nxt_out[7:4];
      end else begin
        nxt_io = out_ff[3:0];
      end
    end
    // Prefetch one byte at a time into the two-entry buffer
    if (reading && !pend_ff && skid_in_ready) begin
      nxt_rdreq = 1'b1;
      nxt_pend = 1'b1;
      nxt_rdaddr = fetch_ff;
      nxt_fetch = qrw_next_addr(fetch_ff, burst_wrap_setting_ff);
    end
  end

  assign reading = (state_ff == ST_DUMMY || state_ff == ST_RDATA) && !cs_high;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 6'h00;
      sh_ff <= 32'h0000_0000;
      quad_ff <= 1'b0;
      is4_ff <= 1'b0;
      addr_ff <= 32'h0000_0000;
      fetch_ff <= 32'h0000_0000;
      rdaddr_ff <= 32'h0000_0000;
      burst_wrap_setting_ff <= '{wrap_size_field: WRAP_SIZE_RESET,
                                 wrap_disable_bit: WRAP_DIS_RESET};
      read_latency_config_ff <= LATENCY_RESET;
      pend_ff <= 1'b0;
      rdreq_ff <= 1'b0;
      out_ff <= 8'h00;
      nib_hi_ff <= 1'b0;
      io_ff <= 4'h0;
      oe_ff <= 4'h0;
      pofs_ff <= 8'h00;
      anyb_ff <= 1'b0;
      mask_ff <= '0;
      go_ff <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      quad_ff <= nxt_quad;
      is4_ff <= nxt_is4;
      addr_ff <= nxt_addr;
      fetch_ff <= nxt_fetch;
      rdaddr_ff <= nxt_rdaddr;
      burst_wrap_setting_ff <= nxt_wrap;
      read_latency_config_ff <= nxt_latency;
      pend_ff <= nxt_pend;
      rdreq_ff <= nxt_rdreq;
      out_ff <= nxt_out;
      nib_hi_ff <= nxt_nib_hi;
      io_ff <= nxt_io;
      oe_ff <= nxt_oe;
      pofs_ff <= nxt_pofs;
      anyb_ff <= nxt_anyb;
      mask_ff <= nxt_mask;
      go_ff <= nxt_go;
    end
  end

  // Late answers after select rises are dropped, not buffered
  qrw_skid u_skid (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .flush_i(cs_high),
    .in_valid_i(rd_valid_i && reading),
    .in_data_i(rd_data_i),
    .in_ready_o(skid_in_ready),
    .out_valid_o(skid_valid),
    .out_data_o(skid_data),
    .out_ready_i(skid_pop)
  );

  // ----------------------------------------------------------------
  // Program engine
  // ----------------------------------------------------------------
  logic run_ff, nxt_run, vld_d_ff, nxt_vld_d, busy_ff, nxt_busy;
  logic [8:0] idx_ff, nxt_idx;
  logic [7:0] idx_d_ff, nxt_idx_d;
  logic pwe_ff, nxt_pwe, wclr_ff, nxt_wclr;
  qrw_prog_type prog_ff, nxt_prog;

  always_comb begin
    nxt_run = run_ff;
    nxt_idx = idx_ff;
    nxt_vld_d = 1'b0;
    nxt_idx_d = idx_ff[7:0];
    nxt_busy = busy_ff;
    nxt_pwe = 1'b0;
    nxt_wclr = 1'b0;
    nxt_prog = prog_ff;
    if (go_ff) begin
      nxt_busy = 1'b1;
      nxt_run = 1'b1;
      nxt_idx = 9'h000;
    end else if (run_ff) begin
      nxt_vld_d = 1'b1;
      nxt_idx = idx_ff + 9'h001;
      nxt_run = (nxt_idx != PAGE_END);
    end else if (busy_ff && !vld_d_ff) begin
      nxt_busy = 1'b0;
      nxt_wclr = 1'b1;
    end
    // Only bytes loaded in this frame are written, all in one page
    if (vld_d_ff && mask_ff[idx_d_ff]) begin
      nxt_pwe = 1'b1;
      nxt_prog.addr = {addr_ff[31:8], idx_d_ff};
      nxt_prog.data = buf_rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      run_ff <= 1'b0;
      idx_ff <= 9'h000;
      vld_d_ff <= 1'b0;
      idx_d_ff <= 8'h00;
      busy_ff <= 1'b0;
      pwe_ff <= 1'b0;
      wclr_ff <= 1'b0;
      prog_ff <= '0;
    end else if (ce_i) begin
      run_ff <= nxt_run;
      idx_ff <= nxt_idx;
      vld_d_ff <= nxt_vld_d;
      idx_d_ff <= nxt_idx_d;
      busy_ff <= nxt_busy;
      pwe_ff <= nxt_pwe;
      wclr_ff <= nxt_wclr;
      prog_ff <= nxt_prog;
    end
  end

  assign engine_busy = busy_ff || go_ff;

  qrw_page_buf u_page (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .we_i(buf_we),
    .waddr_i(pofs_ff),
    .wdata_i(byte_s),
    .raddr_i(idx_ff[7:0]),
    .rdata_o(buf_rdata)
  );

  assign spi_io_o = io_ff;
  assign spi_io_oe_o = oe_ff;
  assign busy_o = busy_ff;
  assign write_latch_clear_o = wclr_ff;
  assign rd_req_o = rdreq_ff;
  assign rd_addr_o = rdaddr_ff;
  assign rd_ready_o = skid_in_ready;
  assign prog_we_o = pwe_ff;
  assign prog_o = prog_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_busy_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && go_ff |=> busy_ff ##1 (busy_ff || !ce_i)) else $error("busy not raised");
  chk_protect_block: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && page_protected_i && !engine_busy |=> !go_ff) else $error("protected page programmed");
  chk_partial_byte: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cs_rise && cnt_ff != 6'h00 |=> !go_ff) else $error("partial byte started program");
  chk_param_bits: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (read_latency_config_ff & ~LATENCY_KEEP_MASK) == 8'h00) else $error("latency bits leaked");
  chk_prog_page: assert property (@(posedge clk_i) disable iff (!resetn_i)
    prog_we_o |-> prog_o.addr[31:8] == addr_ff[31:8]) else $error("program left its page");
  chk_fetch_wrap: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rdreq_ff && !burst_wrap_setting_ff.wrap_disable_bit |->
    ((rdaddr_ff[7:0] ^ addr_ff[7:0]) &
     ~WRAP_MASK_TABLE[burst_wrap_setting_ff.wrap_size_field]) == 8'h00 &&
    rdaddr_ff[31:8] == addr_ff[31:8]) else $error("fetch left wrap section");
  chk_mode_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && cs_fall && quad_peripheral_mode_i |=> state_ff == ST_IGNORE)
    else $error("frame decoded in quad peripheral mode");
  chk_latch_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && sclk_rise && !cs_high && state_ff == ST_OPCODE && cnt_ff == OPC_LAST &&
    (byte_s == OP_PROG3 || byte_s == OP_PROG4) && !write_latch_flag_i
    |=> state_ff == ST_IGNORE) else $error("program taken without latch flag");
  chk_busy_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && busy_ff && !run_ff && !vld_d_ff && !go_ff |=> !busy_o && write_latch_clear_o)
    else $error("busy did not clear");
endmodule

// [bench/qrw_spi_host.sv]
`timescale 1ns/1ps
module qrw_spi_host (
  input wire logic clk_i,
  input wire logic [3:0] io_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o
);
  // ----------------------------------------------------------------
  // Mode 0 host, serial clock idles low between frames
  // ----------------------------------------------------------------
  localparam int HALF = 6;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
  end
  // Released lines toggle so stale data never reads as valid
  task automatic tick(input logic [3:0] d, input logic drv, output logic [3:0] q);
    io_o = drv ? d : ~io_o;
    repeat (HALF) @(negedge clk_i);
    q = io_i;
    sclk_o = 1'b1;
    repeat (HALF) @(negedge clk_i);
    sclk_o = 1'b0;
  endtask
  task automatic bits(input logic [31:0] v, input int n);
    logic [3:0] q;
    for (int i = n - 1; i >= 0; i--) tick({3'h0, v[i]}, 1'b1, q);
  endtask
  task automatic nibs(input logic [31:0] v, input int n);
    logic [3:0] q;
    for (int i = n - 1; i >= 0; i--) tick(v[4 * i +: 4], 1'b1, q);
  endtask
  task automatic start(input logic [7:0] op);
    repeat (HALF) @(negedge clk_i);
    cs_n_o = 1'b0;
    bits(op, 8);
  endtask
  task automatic stop();
    repeat (HALF) @(negedge clk_i);
    cs_n_o = 1'b1;
    io_o = ~io_o;
    repeat (4 * HALF) @(negedge clk_i);
  endtask
endmodule

// [bench/qrw_core_tb.sv]
`timescale 1ns/1ps
module qrw_core_tb;
  import qrw_pkg::*;
  logic clk_i = 1'b0, resetn_i = 1'b0, qio_on = 1'b1, qpm = 1'b0, a4 = 1'b0;
  logic wl = 1'b1, prot = 1'b0, rv = 1'b0, bs = 1'b0, cl = 1'b0;
  logic [7:0] rdat = 8'h00;
  logic [3:0] dio, doe, hio;
  logic cs, sck, busy, clr, rq, rrdy, we;
  logic [31:0] radr;
  qrw_prog_type prog;
  int fails = 0, checked = 0, cyc = 0, nreq = 0, wt = 0;
  logic [39:0] wq[$];
  wire [3:0] io_w = (dio & doe) | (hio & ~doe);

  initial forever #2 clk_i = ~clk_i;
  qrw_spi_host host (.clk_i(clk_i), .io_i(io_w), .cs_n_o(cs), .sclk_o(sck), .io_o(hio));
  qrw_core uut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .spi_cs_n_i(cs),
    .spi_sclk_i(sck), .spi_io_i(io_w), .spi_io_o(dio), .spi_io_oe_o(doe),
    .quad_io_enable_i(qio_on), .quad_peripheral_mode_i(qpm), .addr4_mode_i(a4),
    .write_latch_flag_i(wl), .page_protected_i(prot), .busy_o(busy),
    .write_latch_clear_o(clr), .rd_req_o(rq), .rd_addr_o(radr), .rd_valid_i(rv),
    .rd_data_i(rdat), .rd_ready_o(rrdy), .prog_we_o(we), .prog_o(prog));

  // ----------------------------------------------------------------
  // Array model with random answer delay, monitors, hang guard
  // ----------------------------------------------------------------
  always @(negedge clk_i) begin
    cyc++;
    rv = (wt == 1 && rrdy === 1'b1);
    if (rv) begin
      rdat = fd(radr);
      wt = 0;
    end else if (wt > 1) wt--;
    if (rq === 1'b1) begin
      wt = 1 + $urandom % 3;
      nreq++;
    end
    if (we === 1'b1) wq.push_back({prog.addr, prog.data});
    if (busy === 1'b1) bs = 1'b1;
    if (clr === 1'b1) cl = 1'b1;
    if (cyc == 60000) begin
      fails++;
      complete_run();
    end
  end

  function automatic logic [7:0] fd(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction
  function automatic logic [31:0] nx(input logic [31:0] a, input logic d, input logic [1:0] s);
    logic [7:0] m;
    m = (8'h08 << s) - 8'h01;
    return d ? a + 32'h1 : {a[31:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
  endfunction
  function automatic int dm(input logic [2:0] c);
    return c < 3 ? 6 : 2 * c + 2;
  endfunction

  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input int n, input logic ok,
                    input logic d, input logic [1:0] s, input logic [2:0] c);
    logic [3:0] h, l;
    nreq = 0;
    host.start(op);
    host.nibs(a, (op == OP_QIO_READ4 || a4) ? 8 : 6);
    host.nibs(32'hFF, 2);
    repeat (dm(c)) host.tick(4'h0, 1'b0, h);
    for (int i = 0; i < n; i++) begin
      host.tick(4'h0, 1'b0, h);
      host.tick(4'h0, 1'b0, l);
      if (ok) chk({h, l}, fd(a));
      a = nx(a, d, s);
    end
    host.stop();
    if (!ok) chk(nreq, 0);
  endtask

  task automatic cfg(input logic [2:0] c, input logic d, input logic [1:0] s);
    host.start(OP_PARAM_SET);
    host.bits({1'($urandom), c, 4'($urandom)}, 8);
    host.stop();
    host.start(OP_WRAP_SET);
    host.nibs(32'h0, a4 ? 8 : 6);
    host.nibs({1'($urandom), s, d, 4'($urandom)}, 2);
    host.stop();
  endtask

  task automatic prg(input logic [7:0] op, input logic [31:0] a, input int nb, input int xb,
                     input logic ok);
    logic [7:0] pd[int];
    logic [7:0] v;
    host.start(op);
    host.bits(a, (op == OP_PROG4 || a4) ? 32 : 24);
    for (int i = 0; i < nb; i++) begin
      v = 8'($urandom);
      pd[(a[7:0] + i) % 256] = v;
      host.bits(v, 8);
    end
    host.bits(32'h1, xb);
    bs = 1'b0;
    cl = 1'b0;
    wq.delete();
    host.stop();
    for (int i = 0; i < 400 && !(bs && busy === 1'b0); i++) @(negedge clk_i);
    // Let the monitor see the closing pulse before judging
    repeat (2) @(negedge clk_i);
    chk(bs, ok);
    chk(cl, ok);
    chk(wq.size(), ok ? pd.size() : 0);
    if (ok) foreach (pd[k]) chk(wq.pop_front(), {a[31:8], 8'(k), pd[k]});
  endtask

  task automatic complete_run();
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    logic [31:0] a;
    void'($urandom(32'hB730));
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    a = $urandom & 32'hFFFF_FFFC;
    rd(OP_QIO_READ4, a, 6, 1, 1, 0, 0);
    for (int c = 0; c < 8; c++) begin
      a4 = c[0];
      a = ($urandom & 32'hFFFF_FFC0) | 32'h38;
      if (c[2] && !a4) a[31:24] = 8'h00;
      cfg(3'(c), c == 7, c[1:0]);
      rd(c[2] ? OP_QIO_READ3 : OP_QIO_READ4, a, 20, 1, c == 7, c[1:0], 3'(c));
    end
    a4 = 1'b0;
    qio_on = 1'b0;
    rd(OP_QIO_READ4, 0, 2, 0, 1, 0, 0);
    qio_on = 1'b1;
    qpm = 1'b1;
    rd(OP_QIO_READ4, 0, 2, 0, 1, 0, 0);
    qpm = 1'b0;
    // Mid-run reset must drop both the latency and the wrap setting
    cfg(3'h7, 1'b0, 2'h1);
    resetn_i = 1'b0;
    repeat (4) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (8) @(negedge clk_i);
    a = ($urandom & 32'hFFFF_FFC0) | 32'h3C;
    rd(OP_QIO_READ4, a, 12, 1, 1, 0, 0);
    a = {8'h00, 16'($urandom), 8'hFE};
    prg(OP_PROG3, a, 3, 0, 1);
    prg(OP_PROG4, a, 2, 5, 0);
    wl = 1'b0;
    prg(OP_PROG3, a, 1, 0, 0);
    wl = 1'b1;
    prot = 1'b1;
    prg(OP_PROG4, a, 1, 0, 0);
    prot = 1'b0;
    complete_run();
  end
endmodule
